//--- common/itc_pkg.sv
// constants, opcodes and phase codes for the instruction timing core
package itc_pkg;
  localparam int CYCLE_CLOCKS = 4;
  localparam int DW           = 8;
  localparam int IW           = 16;
  localparam int PC_W         = 11;
  localparam int DMEM_AW      = 8;
  localparam int DMEM_DEPTH   = 256;
  localparam int OPC_LSB      = 11;
  localparam int OPC_W        = 5;
  localparam int SEL_LSB      = 8;
  localparam int SEL_W        = 3;
  localparam int TBL_HIGH_LSB = 8;

  localparam logic [DW-1:0]   PROGRAM_COUNTER_LOW_BYTE_ADDR = 8'h06;
  localparam logic [DW-1:0]   ACC_RST  = 8'h00;
  localparam logic [PC_W-1:0] PC_RST   = 11'h000;
  localparam logic [IW-1:0]   IR_RST   = 16'h0000;
  localparam logic [DW-1:0]   BIT_ONE  = 8'h01;
  localparam logic [DW-1:0]   BYTE_ONE = 8'h01;
  localparam logic [DW-1:0]   BYTE_ZERO = 8'h00;

  // sub codes of the misc group, held in the select field
  localparam logic [SEL_W-1:0] SUB_SUBROUTINE_EXIT = 3'h0;
  localparam logic [SEL_W-1:0] SUB_INTERRUPT_EXIT  = 3'h1;
  localparam logic [SEL_W-1:0] SUB_TABLE_READ      = 3'h2;
  localparam logic [SEL_W-1:0] SUB_HALT            = 3'h3;

  typedef enum logic [3:0] {
    ITC_PH0 = 4'h1,
    ITC_PH1 = 4'h2,
    ITC_PH2 = 4'h4,
    ITC_PH3 = 4'h8
  } itc_phase_t;

  typedef enum logic [4:0] {
    OP_NOP                  = 5'h00,
    OP_TRANSFER_A_M         = 5'h01,
    OP_TRANSFER_M_A         = 5'h02,
    OP_TRANSFER_A_X         = 5'h03,
    OP_ADD_A_M              = 5'h04,
    OP_ADD_A_X              = 5'h05,
    OP_ADD_M                = 5'h06,
    OP_SUB_A_M              = 5'h07,
    OP_SUB_A_X              = 5'h08,
    OP_SUB_M                = 5'h09,
    OP_AND                  = 5'h0a,
    OP_OR                   = 5'h0b,
    OP_XOR                  = 5'h0c,
    OP_COMPLEMENT           = 5'h0d,
    OP_COMPLEMENT_A         = 5'h0e,
    OP_STEP_UP_IN_PLACE     = 5'h0f,
    OP_STEP_UP_TO_ACC       = 5'h10,
    OP_STEP_DOWN_IN_PLACE   = 5'h11,
    OP_STEP_DOWN_TO_ACC     = 5'h12,
    OP_ROTATE_RIGHT         = 5'h13,
    OP_ROTATE_LEFT          = 5'h14,
    OP_ROTATE_RIGHT_CARRY   = 5'h15,
    OP_ROTATE_LEFT_CARRY    = 5'h16,
    OP_BIT_FORCE_HIGH       = 5'h17,
    OP_BIT_FORCE_LOW        = 5'h18,
    OP_SKIP_ZERO            = 5'h19,
    OP_SKIP_NONZERO         = 5'h1a,
    OP_SKIP_BIT_ZERO        = 5'h1b,
    OP_SKIP_BIT_SET         = 5'h1c,
    OP_JUMP                 = 5'h1d,
    OP_CALL                 = 5'h1e,
    OP_MISC                 = 5'h1f
  } itc_op_t;
endpackage

//--- common/itc_dmem_if.sv
// data memory port between the core and its data memory
`timescale 1ns/1ps
interface itc_dmem_if import itc_pkg::*;;
  logic [DMEM_AW-1:0] addr;
  logic [DW-1:0]      wdata;
  logic               we;
  logic [DW-1:0]      rdata;
  modport core (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface

//--- verilog/itc_dmem.sv
// data memory with registered read data
`timescale 1ns/1ps
module itc_dmem import itc_pkg::*; #(
  parameter int DEPTH = DMEM_DEPTH
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  itc_dmem_if.mem   bus
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  if (DEPTH != (1 << DMEM_AW)) begin : g_bad_depth
    $error("itc_dmem depth must match the address width");
  end

  always_ff @(posedge clk_sys) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= BYTE_ZERO;
    end else begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule

//--- verilog/itc_core.sv
// 8-bit core: instruction cycle sequencing, decode, alu, branches and halt
`timescale 1ns/1ps
module itc_core import itc_pkg::*; #(
  parameter int               STACK_DEPTH = 8,
  parameter logic [SEL_W-1:0] TABLE_PAGE  = 3'h7
) (
  input  wire logic            clk_sys,
  input  wire logic            srst,
  output logic [PC_W-1:0]      prog_addr,
  input  wire logic [IW-1:0]   prog_data,
  input  wire logic            wake,
  output logic [DW-1:0]        acc,
  output logic                 carry,
  output logic                 zero,
  output logic                 halted,
  output logic                 int_enable,
  output logic [DW-1:0]        table_high,
  output logic                 cycle_end
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_stack
    $error("itc_core stack depth must be a power of two of at least 2");
  end
  if ($bits(itc_phase_t) != CYCLE_CLOCKS) begin : g_bad_phase
    $error("itc_core phase code must have one bit per system clock of a cycle");
  end

  itc_dmem_if dmem_bus ();

  itc_phase_t       phase_q;
  logic [IW-1:0]    ir_q;
  logic [PC_W-1:0]  pc_q;
  logic [PC_W-1:0]  fetch_q;
  logic             flush_q;
  logic             tbl_q;
  logic [DW-1:0]    tbl_m_q;
  logic [DW-1:0]    tbl_high_q;
  logic             halted_q;
  logic [DW-1:0]    acc_q;
  logic             c_q;
  logic             z_q;
  logic             ie_q;
  logic [SP_W-1:0]  sp_q;
  logic [PC_W-1:0]  stack_q [STACK_DEPTH];

  itc_op_t          op;
  logic [DW-1:0]    m_addr;
  logic [SEL_W-1:0] sel;
  logic [DW-1:0]    src;
  logic [DW-1:0]    imm;
  logic [DW-1:0]    mask;
  logic [DW:0]      sum_m;
  logic [DW:0]      sum_x;
  logic [DW:0]      diff_m;
  logic [DW:0]      diff_x;
  logic [PC_W-1:0]  stack_top;
  logic [PC_W-1:0]  pc_next;
  logic             last;
  logic             exec;
  logic [DW-1:0]    res;
  logic             to_mem;
  logic             to_acc;
  logic             upd_z;
  logic             upd_c;
  logic             c_new;
  logic             skip;
  logic             is_skip_op;
  logic             jump;
  logic             call;
  logic             pop;
  logic             ie_set;
  logic             tbl_go;
  logic             halt_go;
  logic             pcl_wr;
  logic             taken;
  logic             rot_out;

  assign op        = itc_op_t'(ir_q[OPC_LSB +: OPC_W]);
  assign m_addr    = ir_q[DW-1:0];
  assign imm       = ir_q[DW-1:0];
  assign sel       = ir_q[SEL_LSB +: SEL_W];
  assign mask      = BIT_ONE << sel;
  assign src       = (m_addr == PROGRAM_COUNTER_LOW_BYTE_ADDR) ? pc_q[DW-1:0] : dmem_bus.rdata;
  assign sum_m     = {1'b0, acc_q} + {1'b0, src};
  assign sum_x     = {1'b0, acc_q} + {1'b0, imm};
  assign diff_m    = {1'b0, acc_q} - {1'b0, src};
  assign diff_x    = {1'b0, acc_q} - {1'b0, imm};
  assign stack_top = stack_q[sp_q - SP_W'(1)];
  assign last      = (phase_q == ITC_PH3);
  // flushed and table cycles execute nothing
  assign exec      = last && !flush_q && !tbl_q && !halted_q;
  assign rot_out   = (op == OP_ROTATE_RIGHT_CARRY) ? src[0] : src[DW-1];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_q <= ITC_PH0;
    end else if (!halted_q) begin
      case (phase_q)
        ITC_PH0: phase_q <= ITC_PH1;
        ITC_PH1: phase_q <= ITC_PH2;
        ITC_PH2: phase_q <= ITC_PH3;
        ITC_PH3: phase_q <= ITC_PH0;
        default: phase_q <= ITC_PH0;
      endcase
    end
  end

  always_comb begin
    res = BYTE_ZERO;
    to_mem = 1'b0;
    to_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    c_new = 1'b0;
    skip = 1'b0;
    is_skip_op = 1'b0;
    jump = 1'b0;
    call = 1'b0;
    pop = 1'b0;
    ie_set = 1'b0;
    tbl_go = 1'b0;
    halt_go = 1'b0;
    case (op)
      OP_TRANSFER_A_M: begin res = src; to_acc = 1'b1; end
      OP_TRANSFER_M_A: begin res = acc_q; to_mem = 1'b1; end
      OP_TRANSFER_A_X: begin res = imm; to_acc = 1'b1; end
      // carry above 255, carry low on borrow
      OP_ADD_A_M: begin res = sum_m[DW-1:0]; c_new = sum_m[DW]; to_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_ADD_A_X: begin res = sum_x[DW-1:0]; c_new = sum_x[DW]; to_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_ADD_M: begin res = sum_m[DW-1:0]; c_new = sum_m[DW]; to_mem = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_SUB_A_M: begin res = diff_m[DW-1:0]; c_new = ~diff_m[DW]; to_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_SUB_A_X: begin res = diff_x[DW-1:0]; c_new = ~diff_x[DW]; to_acc = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_SUB_M: begin res = diff_m[DW-1:0]; c_new = ~diff_m[DW]; to_mem = 1'b1; upd_z = 1'b1; upd_c = 1'b1; end
      OP_AND: begin res = acc_q & src; to_acc = 1'b1; upd_z = 1'b1; end
      OP_OR: begin res = acc_q | src; to_acc = 1'b1; upd_z = 1'b1; end
      OP_XOR: begin res = acc_q ^ src; to_acc = 1'b1; upd_z = 1'b1; end
      OP_COMPLEMENT: begin res = ~src; to_mem = 1'b1; upd_z = 1'b1; end
      OP_COMPLEMENT_A: begin res = ~src; to_acc = 1'b1; upd_z = 1'b1; end
      OP_STEP_UP_IN_PLACE: begin res = src + BYTE_ONE; to_mem = 1'b1; upd_z = 1'b1; end
      OP_STEP_UP_TO_ACC: begin res = src + BYTE_ONE; to_acc = 1'b1; upd_z = 1'b1; end
      OP_STEP_DOWN_IN_PLACE: begin res = src - BYTE_ONE; to_mem = 1'b1; upd_z = 1'b1; end
      OP_STEP_DOWN_TO_ACC: begin res = src - BYTE_ONE; to_acc = 1'b1; upd_z = 1'b1; end
      OP_ROTATE_RIGHT: begin res = {src[0], src[DW-1:1]}; to_mem = 1'b1; end
      OP_ROTATE_LEFT: begin res = {src[DW-2:0], src[DW-1]}; to_mem = 1'b1; end
      OP_ROTATE_RIGHT_CARRY: begin res = {c_q, src[DW-1:1]}; c_new = src[0]; to_mem = 1'b1; upd_c = 1'b1; end
      OP_ROTATE_LEFT_CARRY: begin res = {src[DW-2:0], c_q}; c_new = src[DW-1]; to_mem = 1'b1; upd_c = 1'b1; end
      OP_BIT_FORCE_HIGH: begin res = src | mask; to_mem = 1'b1; end
      OP_BIT_FORCE_LOW: begin res = src & ~mask; to_mem = 1'b1; end
      OP_SKIP_ZERO: begin skip = (src == BYTE_ZERO); is_skip_op = 1'b1; end
      OP_SKIP_NONZERO: begin skip = (src != BYTE_ZERO); is_skip_op = 1'b1; end
      OP_SKIP_BIT_ZERO: begin skip = ~src[sel]; is_skip_op = 1'b1; end
      OP_SKIP_BIT_SET: begin skip = src[sel]; is_skip_op = 1'b1; end
      OP_JUMP: jump = 1'b1;
      OP_CALL: begin jump = 1'b1; call = 1'b1; end
      OP_MISC: begin
        case (sel)
          SUB_SUBROUTINE_EXIT: pop = 1'b1;
          SUB_INTERRUPT_EXIT: begin pop = 1'b1; ie_set = 1'b1; end
          SUB_TABLE_READ: tbl_go = 1'b1;
          SUB_HALT: halt_go = 1'b1;
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  assign pcl_wr = to_mem && (m_addr == PROGRAM_COUNTER_LOW_BYTE_ADDR);
  // taken skips and redirects cost a cycle
  assign taken  = jump || pop || pcl_wr || skip;

  always_comb begin
    pc_next = pc_q + PC_W'(1);
    if (tbl_q) begin
      pc_next = pc_q;
    end else if (exec && jump) begin
      pc_next = ir_q[PC_W-1:0];
    end else if (exec && pop) begin
      pc_next = stack_top;
    end else if (exec && pcl_wr) begin
      pc_next = {pc_q[PC_W-1:DW], res};
    end
  end

  // two cycle branch and table sequencing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_q <= PC_RST;
      fetch_q <= PC_RST;
      ir_q <= IR_RST;
      tbl_q <= 1'b0;
    end else if (last && !halted_q) begin
      pc_q <= pc_next;
      fetch_q <= (exec && tbl_go) ? {TABLE_PAGE, acc_q} : pc_next;
      tbl_q <= exec && tbl_go;
      if (!tbl_q) begin
        ir_q <= prog_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flush_q <= 1'b0;
    end else if (last && !halted_q) begin
      flush_q <= exec && taken;
    end
  end

  // table word to memory and high latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tbl_m_q <= BYTE_ZERO;
      tbl_high_q <= BYTE_ZERO;
    end else if (exec && tbl_go) begin
      tbl_m_q <= m_addr;
    end else if (tbl_q && last) begin
      tbl_high_q <= prog_data[TBL_HIGH_LSB +: DW];
    end
  end

  assign dmem_bus.addr  = tbl_q ? tbl_m_q : m_addr;
  assign dmem_bus.wdata = tbl_q ? prog_data[DW-1:0] : res;
  assign dmem_bus.we    = last && ((exec && to_mem && !pcl_wr) || tbl_q);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_q <= ACC_RST;
      z_q <= 1'b0;
      c_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (exec) begin
      if (to_acc) begin
        acc_q <= res;
      end
      if (upd_z) begin
        z_q <= (res == BYTE_ZERO);
      end
      if (upd_c) begin
        c_q <= c_new;
      end
      if (ie_set) begin
        ie_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      halted_q <= 1'b0;
    end else if (exec && halt_go) begin
      halted_q <= 1'b1;
    end else if (wake) begin
      halted_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_q <= '0;
    end else if (exec && call) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (exec && pop) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        stack_q[i] <= PC_RST;
      end else if (exec && call && sp_q == SP_W'(i)) begin
        stack_q[i] <= pc_q;
      end
    end
  end

  itc_dmem u_dmem (
    .clk_sys (clk_sys),
    .srst    (srst),
    .bus     (dmem_bus.mem)
  );

  assign prog_addr  = fetch_q;
  assign acc        = acc_q;
  assign carry      = c_q;
  assign zero       = z_q;
  assign halted     = halted_q;
  assign int_enable = ie_q;
  assign table_high = tbl_high_q;
  assign cycle_end  = last && !halted_q;

  a_cycle_four: assert property (@(posedge clk_sys) disable iff (srst)
    (phase_q == ITC_PH0 && !halted_q) |=> phase_q == ITC_PH1 ##1 phase_q == ITC_PH2 ##1 phase_q == ITC_PH3
    ##1 phase_q == ITC_PH0) else $error("instruction cycle is not four clocks");
  a_single_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && !taken && !tbl_go && !halt_go) |-> ##4 (last && !flush_q && !tbl_q))
    else $error("plain instruction took more than one cycle");
  a_jump_target: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && jump) |=> (flush_q && pc_q == $past(ir_q[PC_W-1:0]))) else $error("jump target or flush wrong");
  a_pcl_jump: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && pcl_wr) |=> (flush_q && pc_q[DW-1:0] == $past(res) && fetch_q == pc_q))
    else $error("low byte write did not jump");
  a_skip_extra: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && skip) |=> flush_q ##4 !flush_q) else $error("taken skip timing wrong");
  a_skip_none: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && is_skip_op && !skip) |=> (!flush_q && pc_q == $past(pc_q) + PC_W'(1)))
    else $error("untaken test disturbed the sequence");
  a_call_save: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && call) |=> (stack_q[$past(sp_q)] == $past(pc_q))) else $error("call lost its return address");
  a_exit_resume: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && pop) |=> (pc_q == $past(stack_top) && sp_q == $past(sp_q) - SP_W'(1)))
    else $error("exit did not resume at saved address");
  a_logic_zero: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && (op == OP_AND || op == OP_OR || op == OP_XOR || op == OP_COMPLEMENT_A))
    |=> (z_q == (acc_q == BYTE_ZERO))) else $error("zero flag wrong after logic op");
  a_rotate_carry: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && (op == OP_ROTATE_RIGHT_CARRY || op == OP_ROTATE_LEFT_CARRY)) |=> (c_q == $past(rot_out)))
    else $error("rotate carry wrong");
  a_add_carry: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == OP_ADD_A_M && m_addr != PROGRAM_COUNTER_LOW_BYTE_ADDR)
    |=> (c_q == ($past(acc_q) > ~$past(dmem_bus.rdata)))) else $error("add carry wrong");
  a_step_acc: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == OP_STEP_UP_TO_ACC) |=> (acc_q == $past(src) + BYTE_ONE)) else $error("step up not by one");
  a_bit_low: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == OP_BIT_FORCE_LOW && !pcl_wr)
    |-> (dmem_bus.we && ((dmem_bus.wdata ^ src) & ~mask) == BYTE_ZERO && !dmem_bus.wdata[sel]))
    else $error("bit force low touched other bits");
  a_load_imm: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == OP_TRANSFER_A_X) |=> (acc_q == $past(imm))) else $error("immediate not loaded");
  // table cycle writes the low byte of the fetched word
  a_table_read: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && tbl_go) |-> ##4 (last && tbl_q && dmem_bus.we && dmem_bus.wdata == prog_data[DW-1:0]))
    else $error("table read did not deliver");
  a_halt_enter: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && halt_go) |=> (halted_q && phase_q == ITC_PH0)) else $error("halt not entered");
  a_flush_nop: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && taken) |-> ##4 (last && flush_q && !dmem_bus.we)) else $error("discarded word was executed");
endmodule

//--- test/mcu_instruction_timing_core_tb.sv
// self-checking bench for the instruction timing core
`timescale 1ns/1ps
module mcu_instruction_timing_core_tb import itc_pkg::*;;
  logic            clk_sys;
  logic            srst;
  logic            wake;
  logic [IW-1:0]   prog_data;
  logic [PC_W-1:0] prog_addr;
  logic [DW-1:0]   acc;
  logic [DW-1:0]   table_high;
  logic            carry;
  logic            zero;
  logic            halted;
  logic            int_enable;
  logic            cycle_end;
  logic [IW-1:0]   rom [0:2047];
  int              n_fail;
  int              num_checks;
  int              k;

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // combinational program memory
  assign prog_data = rom[prog_addr];

  itc_core dut_u (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .prog_addr  (prog_addr),
    .prog_data  (prog_data),
    .wake       (wake),
    .acc        (acc),
    .carry      (carry),
    .zero       (zero),
    .halted     (halted),
    .int_enable (int_enable),
    .table_high (table_high),
    .cycle_end  (cycle_end)
  );

  function automatic logic [IW-1:0] ins(input itc_op_t op, input logic [SEL_W-1:0] s, input logic [DW-1:0] d);
    return {op, s, d};
  endfunction

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // clocks from here to the next phase3, bounded
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cycle_end !== 1'b1 && n < 16);
    if (cycle_end !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask

  // let n instruction cycles execute, then look just after the phase3 edge
  task automatic cyc(input int n);
    int m;
    repeat (n) begin
      gap(m);
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic prep();
    @(posedge clk_sys);
    #1;
    srst = 1'b1;
    wake = 1'b0;
    foreach (rom[i]) rom[i] = 16'h0000;
  endtask

  // two reset edges, release, then the reset nop and the word at 0 execute
  task automatic go();
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    cyc(2);
  endtask

  task automatic t_alu();
    prep();
    chk(acc, 16'h0000); // RESET
    chk(prog_addr, 16'h0000); // RESET
    chk(int_enable, 16'h0000); // RESET
    rom[0] = ins(OP_TRANSFER_A_X, 3'h0, 8'hf0);
    rom[1] = ins(OP_ADD_A_X, 3'h0, 8'h20);
    rom[2] = ins(OP_SUB_A_X, 3'h0, 8'h11);
    rom[3] = ins(OP_TRANSFER_M_A, 3'h0, 8'h10);
    rom[4] = ins(OP_XOR, 3'h0, 8'h10);
    rom[5] = ins(OP_STEP_DOWN_TO_ACC, 3'h0, 8'h10);
    rom[6] = ins(OP_STEP_UP_IN_PLACE, 3'h0, 8'h10);
    rom[7] = ins(OP_TRANSFER_A_M, 3'h0, 8'h10);
    go();
    chk(acc, 16'h00f0);
    cyc(1);
    chk({carry, acc}, 16'h0110);
    cyc(2);
    chk({carry, acc}, 16'h00ff);
    cyc(1);
    chk({zero, acc}, 16'h0100);
    cyc(1);
    chk({zero, acc}, 16'h00fe);
    cyc(1);
    chk({zero, acc}, 16'h01fe);
    cyc(1);
    chk(acc, 16'h0000);
  endtask

  task automatic t_branch();
    prep();
    rom[0]     = ins(OP_JUMP, 3'h0, 8'h20);
    rom[1]     = ins(OP_TRANSFER_A_X, 3'h0, 8'h55);
    rom[11'h20] = ins(OP_CALL, 3'h0, 8'h30);
    rom[11'h21] = ins(OP_TRANSFER_A_X, 3'h0, 8'h11);
    rom[11'h30] = ins(OP_TRANSFER_A_X, 3'h0, 8'h22);
    rom[11'h31] = ins(OP_MISC, SUB_SUBROUTINE_EXIT, 8'h00);
    go();
    cyc(1);
    chk(acc, 16'h0000);
    chk(prog_addr, 16'h0021);
    cyc(2);
    chk(acc, 16'h0000);
    cyc(1);
    chk(acc, 16'h0022);
    cyc(2);
    chk(acc, 16'h0022);
    cyc(1);
    chk(acc, 16'h0011);
    gap(k);
    gap(k);
    chk(16'(k), 16'h0004);
  endtask

  task automatic t_skip();
    prep();
    rom[0] = ins(OP_TRANSFER_A_X, 3'h0, 8'h00);
    rom[1] = ins(OP_TRANSFER_M_A, 3'h0, 8'h10);
    rom[2] = ins(OP_SKIP_ZERO, 3'h0, 8'h10);
    rom[3] = ins(OP_TRANSFER_A_X, 3'h0, 8'h77);
    rom[4] = ins(OP_TRANSFER_A_X, 3'h0, 8'h44);
    rom[5] = ins(OP_SKIP_NONZERO, 3'h0, 8'h10);
    rom[6] = ins(OP_TRANSFER_A_X, 3'h0, 8'h66);
    go();
    cyc(3);
    chk(acc, 16'h0000);
    cyc(1);
    chk(acc, 16'h0044);
    cyc(2);
    chk(acc, 16'h0066);
  endtask

  task automatic t_bits();
    prep();
    rom[0] = ins(OP_TRANSFER_A_X, 3'h0, 8'ha5);
    rom[1] = ins(OP_TRANSFER_M_A, 3'h0, 8'h11);
    rom[2] = ins(OP_BIT_FORCE_LOW, 3'h0, 8'h11);
    rom[3] = ins(OP_BIT_FORCE_HIGH, 3'h6, 8'h11);
    rom[4] = ins(OP_TRANSFER_A_M, 3'h0, 8'h11);
    rom[5] = ins(OP_ROTATE_LEFT_CARRY, 3'h0, 8'h11);
    rom[6] = ins(OP_TRANSFER_A_M, 3'h0, 8'h11);
    go();
    cyc(4);
    chk(acc, 16'h00e4);
    cyc(2);
    chk({carry, acc}, 16'h01c8);
  endtask

  task automatic t_pcl();
    prep();
    rom[0]     = ins(OP_TRANSFER_A_X, 3'h0, 8'h40);
    rom[1]     = ins(OP_TRANSFER_M_A, 3'h0, PROGRAM_COUNTER_LOW_BYTE_ADDR);
    rom[2]     = ins(OP_TRANSFER_A_X, 3'h0, 8'h99);
    rom[11'h40] = ins(OP_TRANSFER_A_X, 3'h0, 8'h12);
    rom[11'h41] = ins(OP_CALL, 3'h0, 8'h60);
    rom[11'h42] = ins(OP_TRANSFER_A_X, 3'h0, 8'h34);
    rom[11'h60] = ins(OP_MISC, SUB_INTERRUPT_EXIT, 8'h00);
    go();
    cyc(2);
    chk(acc, 16'h0040);
    cyc(1);
    chk(acc, 16'h0012);
    cyc(2);
    chk(int_enable, 16'h0000);
    cyc(2);
    chk(int_enable, 16'h0001);
    cyc(1);
    chk(acc, 16'h0034);
  endtask

  // memory-operand arithmetic, logic, rotates and bit tests
  task automatic t_more();
    prep();
    rom[0]  = ins(OP_TRANSFER_A_X, 3'h0, 8'h81);
    rom[1]  = ins(OP_TRANSFER_M_A, 3'h0, 8'h20);
    rom[2]  = ins(OP_ADD_A_M, 3'h0, 8'h20);
    rom[3]  = ins(OP_SUB_M, 3'h0, 8'h20);
    rom[4]  = ins(OP_COMPLEMENT_A, 3'h0, 8'h20);
    rom[5]  = ins(OP_AND, 3'h0, 8'h20);
    rom[6]  = ins(OP_OR, 3'h0, 8'h20);
    rom[7]  = ins(OP_COMPLEMENT, 3'h0, 8'h20);
    rom[8]  = ins(OP_STEP_DOWN_IN_PLACE, 3'h0, 8'h20);
    rom[9]  = ins(OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h20);
    rom[10] = ins(OP_ROTATE_LEFT, 3'h0, 8'h20);
    rom[11] = ins(OP_STEP_UP_TO_ACC, 3'h0, 8'h20);
    rom[12] = ins(OP_ROTATE_RIGHT, 3'h0, 8'h20);
    rom[13] = ins(OP_SKIP_BIT_SET, 3'h1, 8'h20);
    rom[14] = ins(OP_TRANSFER_A_X, 3'h0, 8'h99);
    rom[15] = ins(OP_SKIP_BIT_ZERO, 3'h0, 8'h20);
    rom[16] = ins(OP_TRANSFER_A_X, 3'h0, 8'h98);
    rom[17] = ins(OP_TRANSFER_A_M, 3'h0, 8'h20);
    rom[18] = ins(OP_ADD_M, 3'h0, 8'h20);
    rom[19] = ins(OP_SUB_A_M, 3'h0, 8'h20);
    go();
    cyc(2);
    chk({carry, acc}, 16'h0102);
    cyc(2);
    chk({carry, acc}, 16'h007e);
    cyc(1);
    chk({zero, acc}, 16'h0100);
    cyc(1);
    chk({zero, acc}, 16'h0081);
    cyc(5);
    chk({carry, acc}, 16'h017d);
    cyc(6);
    chk(acc, 16'h003e);
    cyc(2);
    chk({carry, acc}, 16'h00c2);
  endtask

  task automatic t_table_halt();
    prep();
    rom[0]         = ins(OP_TRANSFER_A_X, 3'h0, 8'h05);
    rom[1]         = ins(OP_MISC, SUB_TABLE_READ, 8'h12);
    rom[2]         = ins(OP_TRANSFER_A_M, 3'h0, 8'h12);
    rom[3]         = ins(OP_MISC, SUB_HALT, 8'h00);
    rom[4]         = ins(OP_TRANSFER_A_X, 3'h0, 8'h3c);
    rom[{3'h7, 8'h05}] = 16'hbe5a;
    go();
    cyc(2);
    chk(table_high, 16'h00be);
    cyc(1);
    chk(acc, 16'h005a);
    cyc(1);
    chk(halted, 16'h0001);
    repeat (12) @(posedge clk_sys);
    #1;
    chk(halted, 16'h0001);
    chk(prog_addr, 16'h0005);
    wake = 1'b1;
    @(posedge clk_sys);
    #1;
    wake = 1'b0;
    chk(halted, 16'h0000);
    cyc(1);
    chk(acc, 16'h003c);
  endtask

  initial begin
    srst = 1'b1;
    wake = 1'b0;
    n_fail = 0;
    num_checks = 0;
    foreach (rom[i]) rom[i] = 16'h0000;
    t_alu();
    t_branch();
    t_skip();
    t_bits();
    t_pcl();
    t_table_halt();
    t_more();
    finish_test();
  end
endmodule
